/* File: hw/msg_fifo_pkg.sv */
/*
  holds the register map, field positions, reset values and sizes of the message fifo pointer block.
  assumes a 32-bit avalon-mm slave with byte addresses and one core clock.
*/
`default_nettype none
package msg_fifo_pkg;
  // fifo count and pointer widths
  localparam int          NUM_FIFO     = 32;
  localparam int          IDX_W        = 5;
  localparam int          CNT_W        = 6;
  // register byte offsets
  localparam logic [11:0] OFF_MOD_CTL  = 12'h000;
  localparam logic [11:0] OFF_BASE     = 12'h004;
  localparam logic [11:0] OFF_ISTAT    = 12'h008;
  localparam logic [11:0] OFF_IMASK    = 12'h00C;
  localparam logic [11:0] OFF_RXNE     = 12'h010;
  localparam logic [11:0] OFF_TXPEND   = 12'h014;
  localparam logic [11:0] OFF_FIFO_WIN = 12'h100;
  // module control fields
  localparam int          MOD_ON_BIT   = 15;
  localparam int          OPMODE_LSB   = 21;
  localparam logic [2:0]  OPMODE_CFG   = 3'h4;
  // fifo control fields
  localparam int          DEPTH_LSB    = 16;
  localparam int          RST_BIT      = 14;
  localparam int          INC_BIT      = 13;
  localparam int          DATA_ONLY_SELECT_BIT    = 12;
  localparam int          DIR_BIT      = 7;
  localparam int          ABORT_BIT    = 6;
  localparam int          LARB_BIT     = 5;
  localparam int          TX_ERROR_FLAG_BIT    = 4;
  localparam int          SREQ_BIT     = 3;
  // bits of a fifo control word that software may write
  localparam logic [31:0] CTL_WR_MASK  = 32'h001F_1088;
  // buffer strides in bytes
  localparam logic [4:0]  FULL_BYTES   = 5'h10;
  localparam logic [4:0]  DATA_ONLY_SELECT_BYTES  = 5'h08;
  // reset values
  localparam logic [31:0] MOD_CTL_RST  = 32'h0080_0000;
  localparam logic [31:0] ZERO_RST     = 32'h0000_0000;
endpackage : msg_fifo_pkg
`default_nettype wire

/* File: hw/msg_fifo_ptrs.sv */
/*
  holds the head and tail pointer logic of the message fifos kept in system memory,
  with an avalon-mm register slave, a transmit request view and a receive store port.
  assumes the protocol engine runs on core_clk and reports stores and sends by one-cycle strobes.
*/
// How it works
// R01: control bit 7 selects transmit or receive
// R02: transmit fifo reports head buffer address
// R03: increment advances head sixteen bytes, commits
// R04: pointers wrap from last to first buffer
// R05: send request bit asks for transmission
// R06: increment plus send request both act
// R07: receive fifo reports oldest unread buffer
// R08: receive increment steps four or two words
// R09: full receive fifo refuses new stores
// R10: not-empty flag holds while unread remain
// R11: reset bit, config mode, module off
// R12: reset clears pointers, flags, status bits
// R13: software resets only idle fifos; the code resets any fifo whose reset bit is written, busy or not
// R14: reset bit reads set while busy
// R15: only committed transmit buffers are offered
// R16: five-bit depth field sets buffer count
// R17: addresses follow one base, fifos contiguous
// R18: increment is a one-shot write command
`default_nettype none
module msg_fifo_ptrs (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // interrupt
  output logic             irq,
  // transmit engine
  output logic      [31:0] tx_pending,
  input  wire logic        tx_done_valid,
  input  wire logic [4:0]  tx_done_fifo,
  input  wire logic [2:0]  tx_done_status,
  // receive engine
  input  wire logic        rx_store_valid,
  input  wire logic [4:0]  rx_store_fifo,
  output logic             rx_store_ok,
  output logic             rx_store_drop,
  // level view of fifos with unread messages
  output logic      [31:0] rx_not_empty_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [31:0]                                 mod_ctl;     // module_control_reg
    logic [31:0]                                 base;        // fifo_base_address
    logic [31:0]                                 istat;       // sticky receive events
    logic [31:0]                                 imask;       // interrupt mask
    logic [msg_fifo_pkg::NUM_FIFO-1:0][31:0]     ctl;         // fifo_control_reg array
    logic [msg_fifo_pkg::NUM_FIFO-1:0][4:0]      head;        // producer index
    logic [msg_fifo_pkg::NUM_FIFO-1:0][4:0]      tail;        // consumer index
    logic [msg_fifo_pkg::NUM_FIFO-1:0][5:0]      cnt;         // occupied buffers
    logic                                        waitreq;     // bus stall
    logic [31:0]                                 rdata;       // bus read data
    logic                                        irq;         // interrupt level
    logic [31:0]                                 txp;         // transmit offers
    logic [31:0]                                 rxne;        // unread receive fifos
    logic                                        st_ok;       // store accepted pulse
    logic                                        st_drop;     // store refused pulse
  } state_t;

  state_t state_ff;   // registered state
  state_t nxt_state;  // next state

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // next index with wrap at the configured last buffer
  function automatic logic [4:0] ptr_adv(input logic [4:0] p, input logic [31:0] c);
    logic [4:0] last;
    last = c[msg_fifo_pkg::DEPTH_LSB +: 5];
    ptr_adv = (p == last) ? 5'h00 : 5'(p + 5'h01);
  endfunction : ptr_adv

  // bytes per buffer: data-only receive buffers are half size
  function automatic logic [4:0] buf_bytes(input logic [31:0] c);
    if (!c[msg_fifo_pkg::DIR_BIT] && c[msg_fifo_pkg::DATA_ONLY_SELECT_BIT]) begin
      buf_bytes = msg_fifo_pkg::DATA_ONLY_SELECT_BYTES;
    end else begin
      buf_bytes = msg_fifo_pkg::FULL_BYTES;
    end
  endfunction : buf_bytes

  // byte-enable merge of a write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    be_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        be_merge[8*b +: 8] = wd[8*b +: 8];
      end
    end
  endfunction : be_merge

  // physical address of the buffer that software is to use next
  function automatic logic [31:0] user_addr(input state_t s, input logic [4:0] f);
    logic [31:0] acc;
    logic [4:0]  p;
    acc = s.base;
    for (int k = 0; k < msg_fifo_pkg::NUM_FIFO; k++) begin
      if (k < int'(f)) begin
        acc = 32'(acc + ((32'(s.ctl[k][msg_fifo_pkg::DEPTH_LSB +: 5]) + 32'h0000_0001)
                         * 32'(buf_bytes(s.ctl[k]))));
      end
    end
    p = s.ctl[f][msg_fifo_pkg::DIR_BIT] ? s.head[f] : s.tail[f];
    user_addr = 32'(acc + 32'(p) * 32'(buf_bytes(s.ctl[f])));
  endfunction : user_addr

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic       bus_req;     // a request is present
  logic       bus_take;    // request taken this cycle
  logic       win_hit;     // address falls in the fifo window
  logic [4:0] win_idx;     // fifo selected in the window
  logic       mod_reset;   // module wide fifo reset
  logic       inc_go;      // increment command this cycle

  assign bus_req  = avs_read | avs_write;
  assign bus_take = bus_req & state_ff.waitreq;
  assign win_hit  = (avs_address[11:8] == msg_fifo_pkg::OFF_FIFO_WIN[11:8]);
  assign win_idx  = avs_address[7:3];
  // config mode or module off hold all fifos in reset
  assign mod_reset = (state_ff.mod_ctl[msg_fifo_pkg::OPMODE_LSB +: 3] == msg_fifo_pkg::OPMODE_CFG)
                   | ~state_ff.mod_ctl[msg_fifo_pkg::MOD_ON_BIT];
  assign inc_go = bus_take & avs_write & win_hit & ~avs_address[2] & avs_byteenable[1]
                & avs_writedata[msg_fifo_pkg::INC_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [31:0] evt;
    logic [31:0] c;
    logic [4:0]  f;
    evt       = '0;
    c         = '0;
    f         = '0;
    nxt_state = state_ff;
    nxt_state.st_ok   = 1'b0;
    nxt_state.st_drop = 1'b0;

    // transmit engine finished one buffer: retire it, record its status
    if (tx_done_valid) begin
      f = tx_done_fifo;
      c = nxt_state.ctl[f];
      if (c[msg_fifo_pkg::DIR_BIT] && nxt_state.cnt[f] != 6'h00) begin
        // R04: tail wraps
        nxt_state.tail[f] = ptr_adv(nxt_state.tail[f], c);
        nxt_state.cnt[f]  = 6'(nxt_state.cnt[f] - 6'h01);
        nxt_state.ctl[f][msg_fifo_pkg::TX_ERROR_FLAG_BIT +: 3] = c[msg_fifo_pkg::TX_ERROR_FLAG_BIT +: 3] | tx_done_status;
        if (nxt_state.cnt[f] == 6'h00) begin
          nxt_state.ctl[f][msg_fifo_pkg::SREQ_BIT] = 1'b0;
        end
      end
    end

    // receive engine wants to store into a fifo
    if (rx_store_valid) begin
      f = rx_store_fifo;
      c = nxt_state.ctl[f];
      // R09: full receive fifo refuses
      if (!c[msg_fifo_pkg::DIR_BIT] && nxt_state.cnt[f] <= 6'(c[msg_fifo_pkg::DEPTH_LSB +: 5])) begin
        nxt_state.head[f] = ptr_adv(nxt_state.head[f], c);
        nxt_state.cnt[f]  = 6'(nxt_state.cnt[f] + 6'h01);
        nxt_state.st_ok   = 1'b1;
        evt[f]            = 1'b1;
      end else begin
        nxt_state.st_drop = 1'b1;
      end
    end

    // bus: one wait cycle, then answer
    if (bus_take) begin
      nxt_state.waitreq = 1'b0;
      nxt_state.rdata   = '0;
      if (avs_read) begin
        if (win_hit && !avs_address[2]) begin
          // R14: reset bit reads back while busy
          nxt_state.rdata = state_ff.ctl[win_idx];
        end else if (win_hit) begin
          // R02: R07: R17: head or tail address
          nxt_state.rdata = user_addr(state_ff, win_idx);
        end else begin
          case (avs_address)
            msg_fifo_pkg::OFF_MOD_CTL: nxt_state.rdata = state_ff.mod_ctl;
            msg_fifo_pkg::OFF_BASE:    nxt_state.rdata = state_ff.base;
            msg_fifo_pkg::OFF_ISTAT: begin
              nxt_state.rdata = state_ff.istat;
              nxt_state.istat = '0;
            end
            msg_fifo_pkg::OFF_IMASK:   nxt_state.rdata = state_ff.imask;
            msg_fifo_pkg::OFF_RXNE:    nxt_state.rdata = state_ff.rxne;
            msg_fifo_pkg::OFF_TXPEND:  nxt_state.rdata = state_ff.txp;
            default:                   nxt_state.rdata = '0;
          endcase
        end
      end else if (win_hit && !avs_address[2]) begin
        f = win_idx;
        c = be_merge(nxt_state.ctl[f], avs_writedata, avs_byteenable);
        // R01: R05: R16: store direction, depth, data-only, send request
        nxt_state.ctl[f] = (c & msg_fifo_pkg::CTL_WR_MASK)
                         | (nxt_state.ctl[f] & ~msg_fifo_pkg::CTL_WR_MASK);
        if (c[msg_fifo_pkg::RST_BIT]) begin
          nxt_state.ctl[f][msg_fifo_pkg::RST_BIT] = 1'b1;
        end
        // R18: increment is never stored
        nxt_state.ctl[f][msg_fifo_pkg::INC_BIT] = 1'b0;
        if (inc_go) begin
          if (c[msg_fifo_pkg::DIR_BIT]) begin
            // R03: R06: R15: commit loaded buffer
            if (nxt_state.cnt[f] <= 6'(c[msg_fifo_pkg::DEPTH_LSB +: 5])) begin
              nxt_state.head[f] = ptr_adv(nxt_state.head[f], c);
              nxt_state.cnt[f]  = 6'(nxt_state.cnt[f] + 6'h01);
            end
          end else if (nxt_state.cnt[f] != 6'h00) begin
            // R08: R09: release oldest buffer
            nxt_state.tail[f] = ptr_adv(nxt_state.tail[f], c);
            nxt_state.cnt[f]  = 6'(nxt_state.cnt[f] - 6'h01);
          end
        end
      end else begin
        case (avs_address)
          msg_fifo_pkg::OFF_MOD_CTL: nxt_state.mod_ctl = be_merge(state_ff.mod_ctl, avs_writedata, avs_byteenable);
          msg_fifo_pkg::OFF_BASE:    nxt_state.base    = be_merge(state_ff.base, avs_writedata, avs_byteenable);
          msg_fifo_pkg::OFF_IMASK:   nxt_state.imask   = be_merge(state_ff.imask, avs_writedata, avs_byteenable);
          default:                   nxt_state.waitreq = 1'b0;
        endcase
      end
    end else begin
      nxt_state.waitreq = 1'b1;
    end

    // per-fifo reset, one cycle after the request or held by module state
    for (int k = 0; k < msg_fifo_pkg::NUM_FIFO; k++) begin
      // R11: R12: R13: clear pointers, flags, status
      if (state_ff.ctl[k][msg_fifo_pkg::RST_BIT] || mod_reset) begin
        nxt_state.head[k] = '0;
        nxt_state.tail[k] = '0;
        nxt_state.cnt[k]  = '0;
        nxt_state.ctl[k][msg_fifo_pkg::TX_ERROR_FLAG_BIT +: 3] = 3'h0;
        nxt_state.ctl[k][msg_fifo_pkg::SREQ_BIT]       = 1'b0;
        nxt_state.ctl[k][msg_fifo_pkg::RST_BIT]        = 1'b0;
        nxt_state.istat[k] = 1'b0;
        evt[k]             = 1'b0;
        // a store into a fifo under reset is discarded, so report it refused
        if (rx_store_valid && rx_store_fifo == 5'(k)) begin
          nxt_state.st_ok   = 1'b0;
          nxt_state.st_drop = 1'b1;
        end
      end
    end

    // sticky events: set wins over the read clear
    nxt_state.istat = nxt_state.istat | evt;
    for (int k = 0; k < msg_fifo_pkg::NUM_FIFO; k++) begin
      // R10: level while unread remain
      nxt_state.rxne[k] = ~nxt_state.ctl[k][msg_fifo_pkg::DIR_BIT] & (nxt_state.cnt[k] != 6'h00);
      // R15: offer only committed buffers
      nxt_state.txp[k]  = nxt_state.ctl[k][msg_fifo_pkg::DIR_BIT] & nxt_state.ctl[k][msg_fifo_pkg::SREQ_BIT]
                        & (nxt_state.cnt[k] != 6'h00);
    end
    nxt_state.irq = |(nxt_state.istat & nxt_state.imask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk) begin
    if (reset) begin
      // reset values: config mode, module off, bus stalled, all else clear
      state_ff <= '{mod_ctl: msg_fifo_pkg::MOD_CTL_RST, base: msg_fifo_pkg::ZERO_RST,
                    waitreq: 1'b1, default: '0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from the state register
  assign avs_readdata      = state_ff.rdata;
  assign avs_waitrequest   = state_ff.waitreq;
  assign irq               = state_ff.irq;
  assign tx_pending        = state_ff.txp;
  assign rx_store_ok       = state_ff.st_ok;
  assign rx_store_drop     = state_ff.st_drop;
  assign rx_not_empty_flag = state_ff.rxne;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence inc_tx_s;
    inc_go && avs_writedata[msg_fifo_pkg::DIR_BIT] && !mod_reset && !tx_done_valid
      && avs_byteenable[0] && avs_byteenable[2]
      && !state_ff.ctl[win_idx][msg_fifo_pkg::RST_BIT]
      && state_ff.cnt[win_idx] <= 6'(avs_writedata[msg_fifo_pkg::DEPTH_LSB +: 5]);
  endsequence

  sequence inc_rx_s;
    inc_go && !avs_writedata[msg_fifo_pkg::DIR_BIT] && !mod_reset && !rx_store_valid && avs_byteenable[0]
      && !state_ff.ctl[win_idx][msg_fifo_pkg::RST_BIT] && state_ff.cnt[win_idx] != 6'h00;
  endsequence

  head_step_a: assert property (inc_tx_s |=> state_ff.cnt[$past(win_idx)] == 6'($past(state_ff.cnt[win_idx]) + 6'h01)) // R03
    else $error("transmit increment did not commit one buffer");
  tail_step_a: assert property (inc_rx_s |=> state_ff.cnt[$past(win_idx)] == 6'($past(state_ff.cnt[win_idx]) - 6'h01)) // R08
    else $error("receive increment did not release one buffer");
  ptr_wrap_a: assert property (inc_tx_s ##0 (state_ff.head[win_idx] == avs_writedata[msg_fifo_pkg::DEPTH_LSB +: 5])
                               |=> state_ff.head[$past(win_idx)] == 5'h00) // R04
    else $error("head pointer did not wrap to first buffer");
  inc_oneshot_a: assert property (inc_go |=> !inc_go && !state_ff.ctl[$past(win_idx)][msg_fifo_pkg::INC_BIT]) // R18
    else $error("increment bit stayed set");
  mod_reset_a: assert property (mod_reset |=> state_ff.cnt == '0 && state_ff.txp == '0) // R11
    else $error("module reset left fifo state");
  rst_done_a: assert property (bus_take && avs_write && win_hit && !avs_address[2] && avs_byteenable[1]
                               && avs_writedata[msg_fifo_pkg::RST_BIT]
                               |=> state_ff.ctl[$past(win_idx)][msg_fifo_pkg::RST_BIT]
                               ##1 (state_ff.cnt[$past(win_idx, 2)] == 6'h00
                                    && state_ff.ctl[$past(win_idx, 2)][msg_fifo_pkg::TX_ERROR_FLAG_BIT +: 3] == 3'h0)) // R12
    else $error("fifo reset did not clear pointers and status");
  rx_full_a: assert property (rx_store_valid && !mod_reset
                              && state_ff.cnt[rx_store_fifo] > 6'(state_ff.ctl[rx_store_fifo][msg_fifo_pkg::DEPTH_LSB +: 5])
                              |=> rx_store_drop && !rx_store_ok) // R09
    else $error("store accepted into a full receive fifo");
  rxne_level_a: assert property (rx_store_ok |-> rx_not_empty_flag[$past(rx_store_fifo)]) // R10
    else $error("not-empty flag low after accepted store");
  tx_offer_a: assert property (tx_done_valid && tx_done_fifo == 5'h00 && state_ff.cnt[0] == 6'h01 && !bus_take
                               |=> !tx_pending[0]) // R15
    else $error("transmit offered without committed buffer");
  bus_answer_a: assert property (bus_take |=> !avs_waitrequest ##1 avs_waitrequest) // R14
    else $error("bus answer not one cycle after request");

endmodule : msg_fifo_ptrs
`default_nettype wire

/* File: hw/ignore_none.sv */
`default_nettype none
`default_nettype wire

/* File: dv/msg_fifo_ptrs_tb.sv */
/*
  self-checking bench for the message fifo pointer block: register tasks on avalon-mm,
  engine strobe tasks, and directed tests of head, tail, wrap, send request, reset and interrupt.
  assumes the hand-over timing: one-cycle answer on the bus, strobes answered one cycle later.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // clock and reset
  logic        core_clk;
  logic        reset;
  // register bus
  logic [11:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  // engine side
  logic        irq;
  logic [31:0] tx_pending;
  logic        tx_done_valid;
  logic [4:0]  tx_done_fifo;
  logic [2:0]  tx_done_status;
  logic        rx_store_valid;
  logic [4:0]  rx_store_fifo;
  logic        rx_store_ok;
  logic        rx_store_drop;
  logic [31:0] rx_not_empty_flag;
  // bookkeeping
  int          fails;
  int          n_checks;
  int          cycles;
  logic [31:0] rd;
  localparam logic [31:0] BASE = 32'h0000_1000; // buffer area start
  localparam logic [31:0] UA1  = 32'h0000_1040; // fifo1 start: 4 full buffers of fifo0 before it
  localparam logic [31:0] UA2  = 32'h0000_1050; // fifo2 start: plus 2 data-only buffers of fifo1

  msg_fifo_ptrs u_msg_fifo_ptrs (
    .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .tx_pending(tx_pending),
    .tx_done_valid(tx_done_valid), .tx_done_fifo(tx_done_fifo), .tx_done_status(tx_done_status),
    .rx_store_valid(rx_store_valid), .rx_store_fifo(rx_store_fifo), .rx_store_ok(rx_store_ok),
    .rx_store_drop(rx_store_drop), .rx_not_empty_flag(rx_not_empty_flag));

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // clock, cycle count and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // compare and report helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // one bus transfer: request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(what, exp, q);
  endtask : rchk

  // one receive store strobe; ok or drop is looked at in the cycle after the take edge
  task automatic store(input logic [4:0] f, input logic exp_ok);
    @(posedge core_clk);
    rx_store_valid <= 1'b1;
    rx_store_fifo  <= f;
    @(posedge core_clk);
    rx_store_valid <= 1'b0;
    @(posedge core_clk);
    chk("store ok", {31'h0, exp_ok}, {31'h0, rx_store_ok});
    chk("store drop", {31'h0, !exp_ok}, {31'h0, rx_store_drop});
  endtask : store

  // one transmit completion strobe
  task automatic done(input logic [4:0] f, input logic [2:0] st);
    @(posedge core_clk);
    tx_done_valid  <= 1'b1;
    tx_done_fifo   <= f;
    tx_done_status <= st;
    @(posedge core_clk);
    tx_done_valid <= 1'b0;
  endtask : done

  function automatic logic [11:0] ctl(input int n);
    return msg_fifo_pkg::OFF_FIFO_WIN + 12'(8 * n);
  endfunction : ctl

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    core_clk = 1'b0; reset = 1'b1; cycles = 0; fails = 0; n_checks = 0;
    avs_address = 12'h000; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF; tx_done_valid = 1'b0; tx_done_fifo = 5'h00; tx_done_status = 3'h0;
    rx_store_valid = 1'b0; rx_store_fifo = 5'h00;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    // configuration: fifo0 tx 4 buffers, fifo1 rx data-only 2 buffers, fifo2 rx full 2 buffers
    rchk("module control reset", msg_fifo_pkg::OFF_MOD_CTL, msg_fifo_pkg::MOD_CTL_RST);
    rchk("unmapped read", 12'hFF0, 32'h0000_0000);
    wr(12'hFF0, 32'hFFFF_FFFF);
    wr(msg_fifo_pkg::OFF_BASE, BASE);
    wr(ctl(0), 32'h0003_0080);
    wr(ctl(1), 32'h0001_1000);
    wr(ctl(2), 32'h0001_0000);
    wr(msg_fifo_pkg::OFF_IMASK, 32'h0000_0002);
    wr(msg_fifo_pkg::OFF_MOD_CTL, 32'h0000_8000);
    rchk("ua1 start", ctl(1) + 12'h004, UA1);
    rchk("ua2 start", ctl(2) + 12'h004, UA2);
    wr(ctl(0) + 12'h004, 32'h0000_0777);
    rchk("ua0 read only", ctl(0) + 12'h004, BASE);
    $display("test config done");

    // transmit: four commits with increment and send request in one write, head wraps
    for (int i = 0; i < 4; i++) begin
      wr(ctl(0), 32'h0003_2088);
      rchk("ua0 head", ctl(0) + 12'h004, BASE + 32'(((i + 1) % 4) * 16));
    end
    chk("tx pending", 32'h0000_0001, tx_pending);
    rchk("ctl0 inc reads 0", ctl(0), 32'h0003_0088);
    for (int i = 0; i < 4; i++) done(5'd0, (i == 3) ? 3'b111 : 3'b000);
    repeat (2) @(posedge core_clk);
    chk("tx pending drained", 32'h0000_0000, tx_pending);
    rchk("ctl0 status", ctl(0), 32'h0003_00F0);
    wr(ctl(0), 32'h0003_2080);
    rchk("ua0 commit only", ctl(0) + 12'h004, BASE + 32'h10);
    repeat (2) @(posedge core_clk);
    chk("tx no request", 32'h0000_0000, tx_pending);
    $display("test transmit done");

    // fifo reset bit: poll until clear, then pointers and status bits are cleared
    wr(ctl(0), 32'h0003_4080);
    rd = 32'hFFFF_FFFF;
    for (int k = 0; k < 20 && rd[14] !== 1'b0; k++) bus(1'b0, ctl(0), 32'h0000_0000, rd);
    chk("ctl0 after reset", 32'h0003_0080, rd);
    rchk("ua0 after reset", ctl(0) + 12'h004, BASE);
    $display("test fifo reset done");

    // receive data-only: fill, refuse, drain with two-word steps, flag and interrupt
    store(5'd1, 1'b1);
    chk("not empty set", 32'h0000_0002, rx_not_empty_flag);
    store(5'd1, 1'b1);
    store(5'd1, 1'b0);
    store(5'd0, 1'b0);
    repeat (2) @(posedge core_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    rchk("istat", msg_fifo_pkg::OFF_ISTAT, 32'h0000_0002);
    repeat (2) @(posedge core_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rchk("ua1 tail", ctl(1) + 12'h004, UA1);
    wr(ctl(1), 32'h0001_3000);
    rchk("ua1 step", ctl(1) + 12'h004, UA1 + 32'h08);
    chk("not empty held", 32'h0000_0002, rx_not_empty_flag);
    wr(ctl(1), 32'h0001_3000);
    rchk("ua1 wrap", ctl(1) + 12'h004, UA1);
    chk("not empty cleared", 32'h0000_0000, rx_not_empty_flag);
    wr(ctl(1), 32'h0001_3000);
    rchk("ua1 empty inc", ctl(1) + 12'h004, UA1);
    $display("test receive done");

    // receive full buffers, masked event, then module resets by config mode and by off
    store(5'd2, 1'b1);
    repeat (2) @(posedge core_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rchk("istat masked", msg_fifo_pkg::OFF_ISTAT, 32'h0000_0004);
    wr(ctl(2), 32'h0001_2000);
    rchk("ua2 step", ctl(2) + 12'h004, UA2 + 32'h10);
    wr(msg_fifo_pkg::OFF_MOD_CTL, 32'h0080_8000);
    rchk("ua2 config reset", ctl(2) + 12'h004, UA2);
    wr(msg_fifo_pkg::OFF_MOD_CTL, 32'h0000_8000);
    store(5'd2, 1'b1);
    wr(ctl(2), 32'h0001_2000);
    store(5'd2, 1'b1);
    chk("not empty before off", 32'h0000_0004, rx_not_empty_flag);
    wr(msg_fifo_pkg::OFF_MOD_CTL, 32'h0000_0000);
    rchk("ua2 off reset", ctl(2) + 12'h004, UA2);
    chk("flags after off", 32'h0000_0000, rx_not_empty_flag);
    $display("test module reset done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
